//--- src/valley_switch_map.vh
// Purpose: timing counts and encodings of the valley-switch control core
// Assumes: 20 MHz clock, 50 ns period
// Notes: times in their own units, cycle counts derived from them
`ifndef VALLEY_SWITCH_MAP_VH
`define VALLEY_SWITCH_MAP_VH

`define CLK_HZ 20000000
`define SOFT_START_MS 12
`define SOFT_START_STEPS 4
`define SLOW_PERIOD_MS 48
`define SOFT_STEP_CYCLES ((`CLK_HZ / 1000) * `SOFT_START_MS / `SOFT_START_STEPS)
`define SLOW_PERIOD_CYCLES ((`CLK_HZ / 1000) * `SLOW_PERIOD_MS)
`define SHORT_RING_NS 2500
`define LONG_RING_NS 25000
`define SHORT_RING_CYCLES ((`SHORT_RING_NS * 20) / 1000)
`define LONG_RING_CYCLES ((`LONG_RING_NS * 20) / 1000)
`define MAX_OFF_US 50
`define MAX_OFF_CYCLES ((`MAX_OFF_US * `CLK_HZ) / 1000000)
`define OVP_BLANK_US 10
`define OVP_BLANK_CYCLES ((`OVP_BLANK_US * `CLK_HZ) / 1000000)
`define UPDN_MIN 3'h1
`define UPDN_MAX 3'h7
`define VALLEY_MAX 3'h7
`define LIMIT_STEP0 2'h0
`define LIMIT_FULL 2'h3

`endif

//--- src/cycle_timer.v
// Purpose: down-counting one-shot timer with load and done flag
// Assumes: load has priority over counting
// Notes: done is high while the count is zero
`timescale 1ns/1ps
`default_nettype none
module cycle_timer #(
  parameter WIDTH = 24
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // control
  input wire load,
  input wire [WIDTH-1:0] loadValue,
  output wire done
);
  reg [WIDTH-1:0] count;

  always @(posedge clk) begin
    if (sys_rst) begin
      count <= {WIDTH{1'b0}};
    end else if (load) begin
      count <= loadValue;
    end else if (count != {WIDTH{1'b0}}) begin
      count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign done = (count == {WIDTH{1'b0}});
endmodule // cycle_timer
`default_nettype wire

//--- src/sync_two_ff.v
// Purpose: two flip-flop synchroniser for one comparator level
// Assumes: input asynchronous to clk
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // level
  input wire asyncIn,
  output reg syncOut
);
  reg stage1;

  always @(posedge clk) begin
    if (sys_rst) begin
      stage1 <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule // sync_two_ff
`default_nettype wire

//--- src/valley_switch_digital_control.v
// Purpose: digital core of a quasi-resonant flyback controller
// Assumes: comparator outputs asynchronous; sys_rst is the supply power-on reset
// Notes: peak limit is a step index, the analog side maps it to a voltage
// Function
// (RULE1) above turn-on threshold, stop startup charging and begin soft-start switching
// (RULE2) soft-start is time based, 12 ms total, four equal steps
// (RULE3) peak limit steps from 0.32 V up to 1 V unless limited elsewhere
// (RULE4) turn-on decided digitally; turn-off by analog current comparison
// (RULE5) up/down value picks which valley after demagnetisation turns on
// (RULE6) feedback compared to three thresholds; counter updated each 48 ms end
// (RULE7) always below low threshold: count up by one, saturate at 7
// (RULE8) above low but never above high: hold value
// (RULE9) above high but never reset threshold: count down, saturate at 1
// (RULE10) above reset threshold: force counter to 1
// (RULE11) counter stays within 1 to 7; out-of-range steps ignored
// (RULE12) counter starts at 1 after start-up
// (RULE13) low and high thresholds adjusted by line voltage level
// (RULE14) valley counter holds 0 to 7, saturating
// (RULE15) each falling valley crossing after turn-off increments valley counter
// (RULE16) valley counter cleared whenever gate drive goes high
// (RULE17) over-voltage on valley pin in off-time latches off after blanking
// (RULE18) ring suppression long if valley pin below select threshold, else short
// (RULE19) no turn-on while ring suppression runs
// (RULE20) after suppression, turn on when valley count reaches up/down value
// (RULE21) turn on anyway after maximum off interval
// (RULE22) per-period threshold indicators cleared after each update
// (RULE23) slow period and soft-start steps from a reset prescaler
// (RULE24) over-voltage latch persists until power-on reset, gate held low
`timescale 1ns/1ps
`default_nettype none
`include "valley_switch_map.vh"
module valley_switch_digital_control #(
  parameter SOFT_STEP_CYCLES = `SOFT_STEP_CYCLES,
  parameter SLOW_PERIOD_CYCLES = `SLOW_PERIOD_CYCLES,
  parameter SHORT_RING_CYCLES = `SHORT_RING_CYCLES,
  parameter LONG_RING_CYCLES = `LONG_RING_CYCLES,
  parameter MAX_OFF_CYCLES = `MAX_OFF_CYCLES,
  parameter OVP_BLANK_CYCLES = `OVP_BLANK_CYCLES
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // supply comparator
  input wire supplyAboveTurnOn,
  // feedback comparators
  input wire feedbackAboveLow,
  input wire feedbackAboveHigh,
  input wire feedbackAboveReset,
  // valley detect pin comparators
  input wire valleyBelowCrossing,
  input wire valleyAboveOvervoltage,
  input wire valleyBelowRingSelect,
  // current sense comparator, turn-off request
  input wire currentAboveFeedback,
  // line level, selects threshold set for the feedback comparators
  input wire lineHigh,
  // outputs
  output reg gateDrive,
  output reg startupChargeEnable,
  output reg [1:0] peakLimitStep,
  output reg softStartDone,
  output reg [2:0] upDownCount,
  output reg [2:0] valleyCount,
  output reg thresholdSetHigh,
  output reg latchedOff
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  wire [7:0] rawIn;
  wire [7:0] syncIn;
  assign rawIn = {lineHigh, currentAboveFeedback, valleyBelowRingSelect,
    valleyAboveOvervoltage, valleyBelowCrossing, feedbackAboveReset,
    feedbackAboveHigh, feedbackAboveLow};

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gSync
      sync_two_ff uSync (
        .clk(clk),
        .sys_rst(sys_rst),
        .asyncIn(rawIn[g]),
        .syncOut(syncIn[g])
      );
    end
  endgenerate

  wire fbLow = syncIn[0];
  wire fbHigh = syncIn[1];
  wire fbReset = syncIn[2];
  wire zcBelow = syncIn[3];
  wire zcOvp = syncIn[4];
  wire zcRingLow = syncIn[5];
  wire csTrip = syncIn[6];
  wire lineSel = syncIn[7];

  reg supplyMeta;
  reg supplyOk;
  always @(posedge clk) begin
    if (sys_rst) begin
      supplyMeta <= 1'b0;
      supplyOk <= 1'b0;
    end else begin
      supplyMeta <= supplyAboveTurnOn;
      supplyOk <= supplyMeta;
    end
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_ON = 2'h1;
  localparam ST_OFF = 2'h2;
  localparam ST_LATCH = 2'h3;

  reg [1:0] state;
  reg running;
  reg zcBelowPrev;
  reg sawLow;
  reg sawHigh;
  reg sawReset;
  reg ringLoad;
  reg [23:0] ringLoadValue;
  reg offLoad;
  reg ovpLoad;
  reg ovpArmed;
  reg [23:0] slowCount;
  reg [23:0] stepCount;

  wire ringDone;
  wire offDone;
  wire ovpDone;

  cycle_timer #(.WIDTH(24)) uRingTimer (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(ringLoad),
    .loadValue(ringLoadValue),
    .done(ringDone)
  );

  cycle_timer #(.WIDTH(24)) uOffTimer (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(offLoad),
    .loadValue(MAX_OFF_CYCLES[23:0]),
    .done(offDone)
  );

  cycle_timer #(.WIDTH(24)) uOvpTimer (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(ovpLoad),
    .loadValue(OVP_BLANK_CYCLES[23:0]),
    .done(ovpDone)
  );

  // ----------------------------------------------------------------
  // startup and prescaler
  // ----------------------------------------------------------------
  wire slowTick = running && (slowCount == SLOW_PERIOD_CYCLES[23:0] - 24'h1);
  wire stepTick = running && !softStartDone
    && (stepCount == SOFT_STEP_CYCLES[23:0] - 24'h1);

  always @(posedge clk) begin
    if (sys_rst) begin
      running <= 1'b0;
      startupChargeEnable <= 1'b1;
      slowCount <= 24'h0;
      stepCount <= 24'h0;
      peakLimitStep <= `LIMIT_STEP0;
      softStartDone <= 1'b0;
    end else begin
      if (supplyOk && !running) begin
        running <= 1'b1; // [RULE1]
        startupChargeEnable <= 1'b0; // [RULE1]
      end
      if (running) begin
        slowCount <= slowTick ? 24'h0 : slowCount + 24'h1; // [RULE23]
        if (!softStartDone) begin
          stepCount <= stepTick ? 24'h0 : stepCount + 24'h1; // [RULE23]
        end
      end
      if (stepTick) begin
        // step 0 is the lowest limit, step 3 the full limit
        if (peakLimitStep == `LIMIT_FULL) begin
          softStartDone <= 1'b1; // [RULE2]
        end else begin
          peakLimitStep <= peakLimitStep + 2'h1; // [RULE2] [RULE3]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // up/down counter on the slow period
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      upDownCount <= `UPDN_MIN; // [RULE12]
      sawLow <= 1'b0;
      sawHigh <= 1'b0;
      sawReset <= 1'b0;
      thresholdSetHigh <= 1'b0;
    end else begin
      thresholdSetHigh <= lineSel; // [RULE13]
      if (fbReset) begin
        upDownCount <= `UPDN_MIN; // [RULE10]
      end else if (slowTick) begin
        if (sawReset) begin
          upDownCount <= `UPDN_MIN; // [RULE10]
        end else if (sawHigh || fbHigh) begin
          if (upDownCount != `UPDN_MIN) begin
            upDownCount <= upDownCount - 3'h1; // [RULE9] [RULE11]
          end
        end else if (!(sawLow || fbLow)) begin
          if (upDownCount != `UPDN_MAX) begin
            upDownCount <= upDownCount + 3'h1; // [RULE7] [RULE11]
          end
        end
        // otherwise held [RULE8]
      end
      if (slowTick) begin
        // cleared after the decision above has used them [RULE22]
        sawLow <= 1'b0;
        sawHigh <= 1'b0;
        sawReset <= 1'b0;
      end else if (running) begin
        sawLow <= sawLow | fbLow; // [RULE6]
        sawHigh <= sawHigh | fbHigh; // [RULE6]
        sawReset <= sawReset | fbReset; // [RULE6]
      end
    end
  end

  // ----------------------------------------------------------------
  // gate drive state machine
  // ----------------------------------------------------------------
  wire zcFall = zcBelow && !zcBelowPrev;
  wire valleyReached = (valleyCount >= upDownCount);

  always @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      gateDrive <= 1'b0;
      valleyCount <= 3'h0;
      zcBelowPrev <= 1'b0;
      latchedOff <= 1'b0;
      ringLoad <= 1'b0;
      ringLoadValue <= 24'h0;
      offLoad <= 1'b0;
      ovpLoad <= 1'b0;
      ovpArmed <= 1'b0;
    end else begin
      zcBelowPrev <= zcBelow;
      ringLoad <= 1'b0;
      offLoad <= 1'b0;
      ovpLoad <= 1'b0;
      case (state)
        ST_IDLE: begin
          gateDrive <= 1'b0;
          if (running) begin
            state <= ST_ON; // [RULE1]
            gateDrive <= 1'b1;
            valleyCount <= 3'h0; // [RULE16]
          end
        end
        ST_ON: begin
          if (csTrip) begin
            gateDrive <= 1'b0; // [RULE4]
            state <= ST_OFF;
            ringLoad <= 1'b1;
            ringLoadValue <= zcRingLow ? LONG_RING_CYCLES[23:0]
              : SHORT_RING_CYCLES[23:0]; // [RULE18]
            offLoad <= 1'b1;
            ovpArmed <= 1'b0;
          end
        end
        ST_OFF: begin
          if (zcFall && valleyCount != `VALLEY_MAX) begin
            valleyCount <= valleyCount + 3'h1; // [RULE14] [RULE15]
          end
          if (zcOvp && !ovpArmed) begin
            ovpArmed <= 1'b1;
            ovpLoad <= 1'b1;
          end
          if (ovpArmed && ovpDone && !ovpLoad) begin
            state <= ST_LATCH; // [RULE17]
          end else if (!ringLoad && ringDone && (valleyReached || offDone)) begin
            // [RULE19] [RULE20] [RULE21] [RULE5]
            gateDrive <= 1'b1;
            valleyCount <= 3'h0; // [RULE16]
            state <= ST_ON;
          end
        end
        ST_LATCH: begin
          gateDrive <= 1'b0; // [RULE24]
          latchedOff <= 1'b1; // [RULE24]
        end
        default: begin
          state <= ST_IDLE;
          gateDrive <= 1'b0;
        end
      endcase
    end
  end
endmodule // valley_switch_digital_control
`default_nettype wire

//--- testbench/analog_front_model.sv
// Purpose: behavioural comparators and switch stage facing the control core
// Assumes: levels change just after the rising clock edge
// Notes: ringCount sets how many valleys ring out after each turn-off
`timescale 1ns/1ps
`default_nettype none
module analog_front_model (
  // clock and gate
  input wire logic clk,
  input wire logic gateDrive,
  // scenario controls
  input wire logic [2:0] ringCount,
  input wire logic ringSelect,
  input wire logic ovpReq,
  // comparator levels
  output logic currentAboveFeedback,
  output logic valleyBelowCrossing,
  output logic valleyAboveOvervoltage,
  output logic valleyBelowRingSelect
);
  // ----
  // phase since the last gate edge
  // ----
  logic lastGate = 1'h0;
  logic [7:0] phase = 8'h0;
  always @(posedge clk) begin
    lastGate <= gateDrive;
    phase <= (gateDrive != lastGate) ? 8'h0 : phase + {7'h0, phase != 8'hff};
    currentAboveFeedback <= gateDrive && phase >= 8'h4;
    valleyBelowCrossing <= gateDrive || (phase[2] && phase[7:3] < {2'h0, ringCount});
    valleyAboveOvervoltage <= !gateDrive && ovpReq;
    valleyBelowRingSelect <= gateDrive || ringSelect;
  end
endmodule  // analog_front_model
`default_nettype wire

//--- testbench/valley_switch_monitor.sv
// Purpose: port checks for the valley-switch control core
// Assumes: single clock, synchronous active-high reset
// Notes: attached by bind from the bench top file
`timescale 1ns/1ps
`default_nettype none
module valley_switch_monitor #(
  parameter int MAX_OFF_CYCLES = 60
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // comparator levels
  input wire logic supplyAboveTurnOn,
  input wire logic feedbackAboveLow,
  input wire logic feedbackAboveHigh,
  input wire logic feedbackAboveReset,
  input wire logic valleyBelowCrossing,
  input wire logic valleyAboveOvervoltage,
  input wire logic valleyBelowRingSelect,
  input wire logic currentAboveFeedback,
  input wire logic lineHigh,
  // core outputs
  input wire logic gateDrive,
  input wire logic startupChargeEnable,
  input wire logic [1:0] peakLimitStep,
  input wire logic softStartDone,
  input wire logic [2:0] upDownCount,
  input wire logic [2:0] valleyCount,
  input wire logic thresholdSetHigh,
  input wire logic latchedOff
);
  // ----
  // off-time counter and properties
  // ----
  localparam int OFF_LIMIT = MAX_OFF_CYCLES + 6;
  logic [7:0] offCount;
  always @(posedge clk) begin
    if (sys_rst || gateDrive || latchedOff || startupChargeEnable) begin
      offCount <= 8'h0;
    end else if (offCount != 8'hff) begin
      offCount <= offCount + 8'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence limitHeld;
    $stable(peakLimitStep) [*8];
  endsequence
  sequence ovpSeen;
    (valleyAboveOvervoltage && !gateDrive) [*8];
  endsequence
  chk_reset_state: assert property (disable iff (1'h0)
    sys_rst |=> !gateDrive && !latchedOff && upDownCount == 3'h1 && valleyCount == 3'h0)
    else $error("reset state wrong");
  chk_updown_range: assert property (upDownCount >= 3'h1 && upDownCount <= 3'h7)
    else $error("up/down count out of range");
  chk_updown_step: assert property ($changed(upDownCount) |->
    upDownCount == $past(upDownCount) + 3'h1 || upDownCount == $past(upDownCount) - 3'h1
    || upDownCount == 3'h1) else $error("up/down count jumped");
  chk_reset_force: assert property (feedbackAboveReset [*3] |->
    ##[0:2] upDownCount == 3'h1) else $error("up/down count not forced to one");
  chk_valley_step: assert property ($changed(valleyCount) |->
    {1'h0, valleyCount} == {1'h0, $past(valleyCount)} + 4'h1 || (valleyCount == 3'h0 && gateDrive))
    else $error("valley count stepped wrongly");
  chk_ring_block: assert property ($fell(gateDrive) |-> !gateDrive [*4])
    else $error("gate on during ring suppression");
  chk_max_off: assert property (offCount <= OFF_LIMIT)
    else $error("gate off beyond maximum interval");
  chk_latch_hold: assert property (latchedOff |-> !gateDrive ##1 latchedOff)
    else $error("latch released or gate on");
  chk_soft_steps: assert property ($changed(peakLimitStep) |->
    peakLimitStep == $past(peakLimitStep) + 2'h1 ##1 limitHeld)
    else $error("peak limit stepped wrongly");
  chk_ovp_latch: assert property (ovpSeen |-> ##[0:12] latchedOff)
    else $error("over-voltage did not latch");
endmodule  // valley_switch_monitor
`default_nettype wire

//--- testbench/test_valley_switch_digital_control.sv
// Purpose: self-checking bench for the valley-switch control core
// Assumes: shortened timing parameters, 50 ns clock
// Notes: up/down count changes are scored against a queue of expected values
`timescale 1ns/1ps
`default_nettype none
module test_valley_switch_digital_control;
  // ----
  // stimulus, scoring and sequence
  // ----
  localparam int SOFT = 20;
  localparam int SLOW = 80;
  localparam int MAXOFF = 60;
  logic clk = 1'h0, sys_rst = 1'h1, supplyAboveTurnOn = 1'h0, lineHigh = 1'h0;
  logic feedbackAboveLow = 1'h0, feedbackAboveHigh = 1'h0, feedbackAboveReset = 1'h0;
  logic ringSelect = 1'h0, ovpReq = 1'h0, watchUd = 1'h0;
  logic [2:0] ringCount = 3'h7;
  logic currentAboveFeedback, valleyBelowCrossing, valleyAboveOvervoltage, valleyBelowRingSelect;
  logic gateDrive, startupChargeEnable, softStartDone, thresholdSetHigh, latchedOff;
  logic [1:0] peakLimitStep;
  logic [2:0] upDownCount, valleyCount, lastUd;
  logic [2:0] expQ[$];
  int errors = 0, samples_checked = 0, cycles = 0, n = 0, t0 = 0;
  always #25 clk = ~clk;
  valley_switch_digital_control #(.SOFT_STEP_CYCLES(SOFT), .SLOW_PERIOD_CYCLES(SLOW),
    .SHORT_RING_CYCLES(3), .LONG_RING_CYCLES(10), .MAX_OFF_CYCLES(MAXOFF),
    .OVP_BLANK_CYCLES(5)) u_valley_switch_digital_control (.*);
  analog_front_model u_analog_front_model (.*);
  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wait_gate(input logic level);
    n = 0;
    while (gateDrive !== level && n < 200) begin
      @(negedge clk);
      n++;
    end
  endtask
  // scorer pops the oldest expected value on every count change while watchUd is set
  always @(posedge clk) begin
    cycles <= cycles + 1;
    lastUd <= upDownCount;
    if (gateDrive) ringSelect <= 1'($urandom_range(1, 0));
    if (watchUd && upDownCount !== lastUd) begin
      check("upDownCount", upDownCount, expQ.size() ? expQ.pop_front() : 3'h0);
    end
    if (cycles == 6000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(94243));
    repeat (20) @(posedge clk);
    sys_rst <= 1'h0;
    lineHigh <= 1'($urandom_range(1, 0));
    @(negedge clk);
    check("resetState", {gateDrive, startupChargeEnable, peakLimitStep, upDownCount, valleyCount,
      latchedOff}, {1'h0, 1'h1, 2'h0, 3'h1, 3'h0, 1'h0});
    watchUd = 1'h1;
    for (int v = 2; v <= 7; v++) expQ.push_back(3'(v));
    @(posedge clk);
    supplyAboveTurnOn <= 1'h1;
    t0 = cycles;
    @(negedge clk);
    while (startupChargeEnable !== 1'h0 && cycles - t0 < 10) @(negedge clk);
    check("chargeOff", startupChargeEnable, 1'h0);
    check("lineSet", thresholdSetHigh, lineHigh);
    n = cycles;
    while (softStartDone !== 1'h1 && cycles - n < 200) @(negedge clk);
    check("softTime", 12'(cycles - n >= 4 * SOFT - 3 && cycles - n <= 4 * SOFT + 3), 12'h1);
    check("finalLimit", peakLimitStep, 2'h3);
    while (upDownCount !== 3'h7 && cycles - t0 < 7 * SLOW) @(negedge clk);
    check("upTime", 12'(cycles - t0 >= 6 * SLOW && cycles - t0 <= 6 * SLOW + 6), 12'h1);
    @(posedge clk);
    feedbackAboveLow <= 1'h1;
    feedbackAboveHigh <= 1'h1;
    for (int v = 6; v >= 4; v--) expQ.push_back(3'(v));
    repeat (200) @(posedge clk);
    feedbackAboveHigh <= 1'h0;
    repeat (200) @(posedge clk);
    @(negedge clk);
    check("holdValue", {expQ.size() == 0, upDownCount}, {1'h1, 3'h4});
    @(posedge clk);
    feedbackAboveHigh <= 1'h1;
    feedbackAboveReset <= 1'h1;
    expQ.push_back(3'h1);
    repeat (6) @(posedge clk);
    {feedbackAboveLow, feedbackAboveHigh, feedbackAboveReset} <= 3'h0;
    @(negedge clk);
    check("forcedOne", {expQ.size() == 0, upDownCount}, {1'h1, 3'h1});
    watchUd = 1'h0;
    wait_gate(1'h1);
    wait_gate(1'h0);
    t0 = cycles;
    wait_gate(1'h1);
    check("valleyOn", 12'(cycles - t0 >= 4 && cycles - t0 <= 30), 12'h1);
    check("valleyClear", valleyCount, 3'h0);
    @(posedge clk);
    ringCount <= 3'h0;
    wait_gate(1'h1);
    wait_gate(1'h0);
    t0 = cycles;
    wait_gate(1'h1);
    check("maxOff", 12'(cycles - t0 >= MAXOFF - 3 && cycles - t0 <= MAXOFF + 4), 12'h1);
    wait_gate(1'h0);
    @(posedge clk);
    ovpReq <= 1'h1;
    t0 = cycles;
    while (latchedOff !== 1'h1 && cycles - t0 < 20) @(negedge clk);
    check("latched", latchedOff, 1'h1);
    @(posedge clk);
    ovpReq <= 1'h0;
    repeat (150) @(negedge clk);
    check("stillLatched", {latchedOff, gateDrive}, {1'h1, 1'h0});
    @(posedge clk);
    sys_rst <= 1'h1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'h0;
    @(negedge clk);
    check("rerun", {latchedOff, upDownCount, startupChargeEnable}, {1'h0, 3'h1, 1'h1});
    report_and_stop();
  end
endmodule  // test_valley_switch_digital_control
bind valley_switch_digital_control valley_switch_monitor #(.MAX_OFF_CYCLES(MAX_OFF_CYCLES))
  u_valley_switch_monitor (.*);
`default_nettype wire
